//--- rtl/pxs_serializer.sv
// pixel serializer: word fifo and 21-to-3 serializer top
// Behaviour
// [R01] three seven-bit shift registers, one per lane
// [R02] capture all 21 inputs on pixel clock fall
// [R03] bit rate locked to pixel clock, seven slots
// [R04] forwarded clock at pixel clock frequency
// [R05] power down stops clock, drivers off
// [R06] power down low clears every register; fifo storage and input synchronisers are not cleared
// [R07] bit n at n sevenths after rise
// [R08] forwarded clock high four of seven slots
// [R09] controller keeps pixel clock 31-75 MHz
// [R10] lock and valid lanes within 1 ms
// [R11] power down drops forwarded clock low quickly
// [R12] bit rate tracks spread-spectrum pixel clock
// [R13] inputs 0-6,7-13,14-20 to lanes, lsb first
`timescale 1ns/1ns
module pxs_fifo #(
  parameter int W     = 21,
  parameter int DEPTH = 16
) (
  // clock and clear
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         clr_i,
  // fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  // refused at elaboration: pointer wrap needs a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
    $error("pxs_fifo: depth must be a power of two");
  end
  logic [W-1:0] mem_ff [DEPTH];
  logic [AW:0]  wr_ff;
  logic [AW:0]  rd_ff;
  logic [AW:0]  nxt_wr;
  logic [AW:0]  nxt_rd;
  logic         push;
  logic         pop;
  assign in_ready_o  = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_ff != rd_ff;
  assign out_data_o  = mem_ff[rd_ff[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  always_comb begin
    nxt_wr = clr_i ? '0 : (push ? wr_ff + 1'b1 : wr_ff);
    nxt_rd = clr_i ? '0 : (pop ? rd_ff + 1'b1 : rd_ff);
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
  end
  // storage needs no reset; pointers decide what is valid
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ff[AW-1:0]] <= in_data_i;
    end
  end
endmodule

module pxs_serializer
  import pxs_pkg::*;
#(
  parameter int EN_CYC = PXS_EN_CYC
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  // controller side pins
  input  wire logic                  pixel_clock_in_i,
  input  wire logic [PXS_DATA_W-1:0] parallel_data_in_i,
  input  wire logic                  power_down_clear_n_i,
  // panel side lines
  output logic                       serial_lane0_o,
  output logic                       serial_lane1_o,
  output logic                       serial_lane2_o,
  output logic                       forwarded_clock_o,
  output logic                       line_drive_oe_n_o,
  // status
  output logic                       locked_o,
  output logic                       lock_timeout_o,
  output logic                       overrun_o
);
  if (EN_CYC < 1) begin : g_en_chk
    $error("pxs_serializer: EN_CYC must be positive");
  end
  localparam int PW = PXS_PERIOD_W;
  localparam int WW = $clog2(EN_CYC + 1);
  // input synchronisers
  logic                  pclk_s1_ff, pclk_s2_ff, pclk_s3_ff;
  logic                  pd_s1_ff, pd_s2_ff;
  logic [PXS_DATA_W-1:0] data_s1_ff, data_s2_ff;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pclk_s1_ff <= 1'b0;
      pclk_s2_ff <= 1'b0;
      pclk_s3_ff <= 1'b0;
      pd_s1_ff   <= 1'b0;
      pd_s2_ff   <= 1'b0;
      data_s1_ff <= '0;
      data_s2_ff <= '0;
    end else begin
      pclk_s1_ff <= pixel_clock_in_i;
      pclk_s2_ff <= pclk_s1_ff;
      pclk_s3_ff <= pclk_s2_ff;
      pd_s1_ff   <= power_down_clear_n_i;
      pd_s2_ff   <= pd_s1_ff;
      data_s1_ff <= parallel_data_in_i;
      data_s2_ff <= data_s1_ff;
    end
  end
  logic                  pclk_fall;
  assign pclk_fall = pclk_s3_ff && !pclk_s2_ff;
  // main state
  pxs_state_t            state_ff, nxt_state;
  logic [PW-1:0]         cnt_ff, nxt_cnt;
  logic [PW-1:0]         period_ff, nxt_period;
  logic [PW-1:0]         acc_ff, nxt_acc;
  logic [1:0]            edges_ff, nxt_edges;
  logic [WW-1:0]         wd_ff, nxt_wd;
  logic [PXS_SLOT_W-1:0] slot_ff, nxt_slot;
  logic [PXS_BITS-1:0]   sh_ff [PXS_LANES];
  logic [PXS_BITS-1:0]   nxt_sh [PXS_LANES];
  logic [PXS_LANES-1:0]  lane_ff, nxt_lane;
  logic                  fwd_ff, nxt_fwd;
  logic                  oe_n_ff, nxt_oe_n;
  logic                  tmo_ff, nxt_tmo;
  logic                  ovr_ff, nxt_ovr;
  logic                  locked_ff, nxt_locked;
  logic                  push_v, fifo_in_rdy, fifo_out_v, pop;
  logic [PXS_DATA_W-1:0] fifo_word;
  logic [PW:0]           acc_sum;
  logic                  tick;
  // [R02] capture on fall
  assign push_v = pclk_fall && (state_ff == PXS_RUN);
  pxs_fifo #(.W(PXS_DATA_W), .DEPTH(PXS_FIFO_DEPTH)) u_fifo (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .clr_i      (!pd_s2_ff),
    .in_valid_i (push_v),
    .in_ready_o (fifo_in_rdy),
    .in_data_i  (data_s2_ff),
    .out_valid_o(fifo_out_v),
    .out_ready_i(pop),
    .out_data_o (fifo_word)
  );
  // [R03] fractional divider, seven ticks per measured period
  assign acc_sum = {1'b0, acc_ff} + (PW+1)'(PXS_BITS);
  assign tick    = (state_ff == PXS_RUN) && (acc_sum >= {1'b0, period_ff});
  assign pop     = tick && (slot_ff == '0) && fifo_out_v;
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = (cnt_ff == '1) ? cnt_ff : cnt_ff + 1'b1;
    nxt_period = period_ff;
    nxt_acc    = acc_ff;
    nxt_edges  = edges_ff;
    nxt_wd     = wd_ff;
    nxt_slot   = slot_ff;
    nxt_sh     = sh_ff;
    nxt_lane   = lane_ff;
    nxt_fwd    = fwd_ff;
    nxt_oe_n   = (state_ff != PXS_RUN);
    nxt_tmo    = tmo_ff;
    nxt_ovr    = ovr_ff || (push_v && !fifo_in_rdy);
    // [R12] period re-measured at every pixel clock fall so the rate follows drift
    if (pclk_fall) begin
      nxt_cnt    = '0;
      nxt_period = cnt_ff + 1'b1;
      nxt_edges  = (edges_ff == PXS_EDGES_LOCK) ? edges_ff : edges_ff + 1'b1;
    end
    unique case (state_ff)
      PXS_OFF: begin
        nxt_state = PXS_LOCK;
      end
      PXS_LOCK: begin
        // [R10] lock after two edges, watchdog flags a 1 ms miss
        if (edges_ff == PXS_EDGES_LOCK) begin
          nxt_state = PXS_RUN;
        end else if (wd_ff == WW'(EN_CYC)) begin
          nxt_tmo = 1'b1;
        end else begin
          nxt_wd = wd_ff + 1'b1;
        end
      end
      PXS_RUN: begin
        if (tick) begin
          nxt_acc = acc_sum[PW-1:0] - period_ff;
          if (slot_ff == '0) begin
            // [R04] one forwarded period per word
            if (fifo_out_v) begin
              for (int i = 0; i < PXS_LANES; i++) begin
                // [R13] lane mapping, lowest input first
                nxt_lane[i] = fifo_word[i*PXS_BITS];
                // [R01] parallel load, serial shift
                nxt_sh[i]   = {1'b0, fifo_word[i*PXS_BITS+1 +: PXS_BITS-1]};
              end
              nxt_fwd  = 1'b1;
              nxt_slot = 3'h1;
            end else begin
              // starved: hold the clock low rather than send stale bits
              nxt_fwd = 1'b0;
            end
          end else begin
            for (int i = 0; i < PXS_LANES; i++) begin
              // [R07] one bit per seventh of the period
              nxt_lane[i] = sh_ff[i][0];
              nxt_sh[i]   = sh_ff[i] >> 1;
            end
            // [R08] high for slots 0 to 3 only
            nxt_fwd  = (slot_ff < PXS_SLOT_HIGH);
            nxt_slot = (slot_ff == PXS_SLOT_LAST) ? '0 : slot_ff + 1'b1;
          end
        end else begin
          nxt_acc = acc_sum[PW-1:0];
        end
      end
    endcase
    // [R05] [R06] [R11] power down clears the state, counters, shifters, flags and fifo pointers and stops the clock
    if (!pd_s2_ff) begin
      nxt_state  = PXS_OFF;
      nxt_cnt    = '0;
      nxt_period = '0;
      nxt_acc    = '0;
      nxt_edges  = PXS_EDGES_RST;
      nxt_wd     = '0;
      nxt_slot   = '0;
      nxt_lane   = '0;
      nxt_fwd    = 1'b0;
      nxt_oe_n   = PXS_OE_N_RST;
      nxt_tmo    = 1'b0;
      nxt_ovr    = 1'b0;
      for (int i = 0; i < PXS_LANES; i++) begin
        nxt_sh[i] = '0;
      end
    end
    nxt_locked = (nxt_state == PXS_RUN);
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff  <= PXS_OFF;
      cnt_ff    <= '0;
      period_ff <= '0;
      acc_ff    <= '0;
      edges_ff  <= PXS_EDGES_RST;
      wd_ff     <= '0;
      slot_ff   <= '0;
      lane_ff   <= '0;
      fwd_ff    <= 1'b0;
      oe_n_ff   <= PXS_OE_N_RST;
      tmo_ff    <= 1'b0;
      ovr_ff    <= 1'b0;
      locked_ff <= 1'b0;
      for (int i = 0; i < PXS_LANES; i++) begin
        sh_ff[i] <= '0;
      end
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      period_ff <= nxt_period;
      acc_ff    <= nxt_acc;
      edges_ff  <= nxt_edges;
      wd_ff     <= nxt_wd;
      slot_ff   <= nxt_slot;
      lane_ff   <= nxt_lane;
      fwd_ff    <= nxt_fwd;
      oe_n_ff   <= nxt_oe_n;
      tmo_ff    <= nxt_tmo;
      ovr_ff    <= nxt_ovr;
      locked_ff <= nxt_locked;
      sh_ff     <= nxt_sh;
    end
  end
  // every output straight from a register
  assign serial_lane0_o    = lane_ff[0];
  assign serial_lane1_o    = lane_ff[1];
  assign serial_lane2_o    = lane_ff[2];
  assign forwarded_clock_o = fwd_ff;
  assign line_drive_oe_n_o = oe_n_ff;
  assign locked_o          = locked_ff;
  assign lock_timeout_o    = tmo_ff;
  assign overrun_o         = ovr_ff;
endmodule

//--- include/pxs_pkg.sv
// shared constants for the 21-to-3 pixel serializer
package pxs_pkg;
  localparam int          PXS_DATA_W       = 21;
  localparam int          PXS_LANES        = 3;
  localparam int          PXS_BITS         = 7;
  localparam int          PXS_HIGH_SLOTS   = 4;
  localparam int          PXS_FIFO_DEPTH   = 16;
  localparam int          PXS_PERIOD_W     = 8;
  localparam int          PXS_SLOT_W       = 3;
  localparam int          PXS_LOCK_EDGES   = 2;
  localparam int          PXS_CLK_PERIOD_NS = 10;
  localparam int          PXS_EN_TIME_NS   = 1_000_000;
  localparam int          PXS_EN_CYC       = PXS_EN_TIME_NS / PXS_CLK_PERIOD_NS;
  localparam logic        PXS_OE_N_RST     = 1'b1;
  localparam logic [2:0]  PXS_SLOT_LAST    = 3'h6;
  localparam logic [2:0]  PXS_SLOT_HIGH    = 3'h4;
  localparam logic [1:0]  PXS_EDGES_RST    = 2'h0;
  localparam logic [1:0]  PXS_EDGES_LOCK   = 2'h2;
  typedef enum logic [1:0] {PXS_OFF, PXS_LOCK, PXS_RUN} pxs_state_t;
endpackage

//--- verif/pxs_serializer_assertions.sv
// port assertions for the pixel serializer
`timescale 1ns/1ns
module pxs_serializer_assertions (
  // watched ports
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic power_down_clear_n_i,
  input wire logic serial_lane0_o,
  input wire logic forwarded_clock_o,
  input wire logic line_drive_oe_n_o,
  input wire logic locked_o,
  input wire logic lock_timeout_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // pin low long enough to pass the sync pipe
  sequence s_pd_held;
    !power_down_clear_n_i [*4];
  endsequence
  sequence s_pu_held;
    power_down_clear_n_i [*3];
  endsequence
  off_state_a: assert property (
    s_pd_held |-> line_drive_oe_n_o && !forwarded_clock_o) else $error("not off");
  pd_clear_a: assert property (
    s_pd_held |-> !locked_o && !lock_timeout_o && !serial_lane0_o) else $error("not clear");
  drive_gate_a: assert property (
    forwarded_clock_o |-> !line_drive_oe_n_o) else $error("clock while off");
  lane_quiet_a: assert property (
    line_drive_oe_n_o |-> !serial_lane0_o) else $error("lane while off");
  oe_after_lock_a: assert property (
    $rose(locked_o) |=> !line_drive_oe_n_o) else $error("oe late");
  oe_needs_lock_a: assert property (
    $fell(line_drive_oe_n_o) |-> $past(locked_o)) else $error("oe early");
  clk_high_min_a: assert property (disable iff (!rst_n_i || !power_down_clear_n_i)
    $rose(forwarded_clock_o) |-> forwarded_clock_o [*4]) else $error("short high");
  timeout_hold_a: assert property (
    s_pu_held ##0 lock_timeout_o |=> lock_timeout_o) else $error("flag lost");
endmodule
bind pxs_serializer pxs_serializer_assertions u_pxs_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .power_down_clear_n_i(power_down_clear_n_i),
  .serial_lane0_o(serial_lane0_o), .forwarded_clock_o(forwarded_clock_o),
  .line_drive_oe_n_o(line_drive_oe_n_o), .locked_o(locked_o),
  .lock_timeout_o(lock_timeout_o));

//--- verif/pxs_panel_model.sv
// panel receiver model: slices at clock edges, period
`timescale 1ns/1ns
module pxs_panel_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // lines in
  input  wire logic [2:0] lanes_i,
  input  wire logic       fwd_i,
  // recovered data
  output logic [5:0]      frame_o,
  output logic [7:0]      period_o,
  output logic [20:0]     word_o
);
  logic       fwd_q;
  logic [7:0] cnt;
  logic [2:0] mid;
  // mid-slot points for the 16-clock bench period; seven marks none
  function automatic logic [2:0] mid_slot(input logic [7:0] c);
    case (c)
      8'h00: return 3'h0;
      8'h02: return 3'h1;
      8'h04: return 3'h2;
      8'h07: return 3'h3;
      8'h09: return 3'h4;
      8'h0B: return 3'h5;
      8'h0D: return 3'h6;
      default: return 3'h7;
    endcase
  endfunction
  assign mid = mid_slot(cnt);
  // bit 0 at rise, bit 4 at fall
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fwd_q <= 1'b0;
      cnt <= 8'h00;
      frame_o <= 6'h00;
      period_o <= 8'h00;
      word_o <= 21'h00_0000;
    end else begin
      fwd_q <= fwd_i;
      cnt <= cnt + 8'h01;
      if (fwd_i && !fwd_q) begin
        frame_o[2:0] <= lanes_i;
        period_o <= cnt + 8'h01;
        cnt <= 8'h00;
      end
      if (!fwd_i && fwd_q) frame_o[5:3] <= lanes_i;
      // every bit of each lane, at mid-slot
      if (mid != 3'h7) begin
        word_o[mid]      <= lanes_i[0];
        word_o[mid + 7]  <= lanes_i[1];
        word_o[mid + 14] <= lanes_i[2];
      end
    end
  end
endmodule

//--- verif/testbench.sv
// self-checking bench for the pixel serializer
`timescale 1ns/1ns
module testbench;
  import pxs_pkg::*;
  localparam int EN = 200;
  logic                  clk, rst_n, pclk, pdn, run;
  logic [PXS_DATA_W-1:0] data;
  logic                  l0, l1, l2, fwd, oe_n, lk, tmo, ovr, slow;
  logic [5:0]            frame;
  logic [7:0]            per;
  logic [20:0]           word;
  logic [4:0]            pdiv;
  int                    bad_count = 0;
  int                    n_checks = 0;
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // pixel clock of 16 or 18 cycles, still when stopped
  // legal period and duty
  always @(posedge clk) begin
    pdiv <= (!run || pdiv >= (slow ? 5'h11 : 5'h0F)) ? 5'h00 : pdiv + 5'h01;
    pclk <= run & (pdiv >= 5'h08);
  end
  pxs_serializer #(.EN_CYC(EN)) u_pxs_serializer (
    .clk_i(clk), .rst_n_i(rst_n), .pixel_clock_in_i(pclk),
    .parallel_data_in_i(data), .power_down_clear_n_i(pdn),
    .serial_lane0_o(l0), .serial_lane1_o(l1), .serial_lane2_o(l2),
    .forwarded_clock_o(fwd), .line_drive_oe_n_o(oe_n), .locked_o(lk),
    .lock_timeout_o(tmo), .overrun_o(ovr));
  pxs_panel_model u_pxs_panel_model (.clk_i(clk), .rst_n_i(rst_n),
    .lanes_i({l2, l1, l0}), .fwd_i(fwd), .frame_o(frame), .period_o(per), .word_o(word));
  function automatic logic [5:0] slc(input logic [20:0] w);
    return {w[18], w[11], w[4], w[14], w[7], w[0]};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // bounded wait: a lock that never comes ends the run
  task automatic wait_lock();
    for (int i = 0; i < 200 && lk !== 1'b1; i++) @(posedge clk);
    if (lk !== 1'b1) begin
      @(negedge clk);
      cmp(lk, 8'h01);
      finish_test();
    end else begin
      repeat (2) @(posedge clk);
    end
  endtask
  // checks look mid-cycle at settled outputs, drives stay on rising edges
  task automatic t_reset();
    @(negedge clk);
    cmp({oe_n, lk, fwd, l0, tmo}, 8'h10);
    @(posedge clk);
  endtask
  task automatic t_lock();
    run <= 1'b1;
    pdn <= 1'b1;
    wait_lock();
    @(negedge clk);
    cmp(oe_n, 8'h00);
    cmp(tmo, 8'h00);
    @(posedge clk);
  endtask
  // first and last words hit all-zero and all-one slices
  task automatic t_map();
    logic [20:0] w [5] = '{21'h00_0000, 21'h00_0011, 21'h04_4080,
                           21'h00_0880, 21'h1F_FFFF};
    foreach (w[k]) begin
      data <= w[k];
      repeat (64) @(posedge clk);
      @(negedge clk);
      cmp(frame, slc(w[k]));
      cmp(word, w[k]);
      cmp(per, 8'h10);
      cmp(ovr, 8'h00);
      @(posedge clk);
    end
  endtask
  // pixel period stretched to 18 clocks while running
  task automatic t_drift();
    slow <= 1'b1;
    data <= 21'h15_3C0F;
    repeat (80) @(posedge clk);
    @(negedge clk);
    cmp(per, 8'h12);
    cmp(frame, slc(21'h15_3C0F));
    @(posedge clk);
    slow <= 1'b0;
  endtask
  task automatic t_pd();
    pdn <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    cmp({oe_n, fwd, lk, l0}, 8'h08);
    cmp(ovr, 8'h00);
    @(posedge clk);
    data <= 21'h0A_5A5A;
    pdn <= 1'b1;
    wait_lock();
    repeat (64) @(posedge clk);
    @(negedge clk);
    cmp(frame, slc(21'h0A_5A5A));
    cmp(word, 21'h0A_5A5A);
    @(posedge clk);
  endtask
  task automatic t_timeout();
    run <= 1'b0;
    pdn <= 1'b0;
    repeat (4) @(posedge clk);
    pdn <= 1'b1;
    repeat (EN + 20) @(posedge clk);
    @(negedge clk);
    cmp({tmo, lk, fwd}, 8'h04);
    @(posedge clk);
    pdn <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    cmp(tmo, 8'h00);
  endtask
  initial begin
    rst_n = 0;
    pdn = 0;
    run = 0;
    slow = 0;
    data = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_lock();
    t_map();
    t_drift();
    t_pd();
    t_timeout();
    finish_test();
  end
endmodule
